// file: hdl/dpo_pkg.sv
// constants and types shared by the dose pulse overflow interlock
package dpo_pkg;

   // ****************************************
   // clock
   // ****************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_MHZ = 25;

   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [5:0] ADDR_CTRL = 6'h00;
   localparam logic [5:0] ADDR_TARGET = 6'h04;
   localparam logic [5:0] ADDR_FILT = 6'h08;
   localparam logic [5:0] ADDR_UNFILT = 6'h0C;
   localparam logic [5:0] ADDR_STATUS = 6'h10;
   localparam logic [5:0] ADDR_BEEP = 6'h14;
   localparam logic [5:0] ADDR_SPOT = 6'h18;
   localparam logic [5:0] ADDR_KICK = 6'h1C;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_CNTRST = 0;
   localparam int CTRL_RETX = 1;
   localparam int CTRL_WDEN = 2;
   localparam int CTRL_STARTOK = 3;
   localparam int CTRL_PAUSEOK = 4;
   localparam int ST_KEY = 0;
   localparam int ST_PAUSE = 2;
   localparam int ST_OVF = 3;
   localparam int ST_CABLE = 4;
   localparam int ST_RELAY = 5;
   localparam int ST_WD = 6;
   localparam int ST_SPOTOK = 7;
   localparam int BEEP_PPT = 0;
   localparam int BEEP_VOL = 16;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [15:0] PPT_RST = 16'h0064;
   localparam logic [3:0] VOL_RST = 4'h8;
   localparam logic [3:0] VOL_MIN = 4'h1;

   // ****************************************
   // times and cycle counts
   // ****************************************
   localparam int WDOG_MS = 100;
   localparam int RELAY_MS = 20;
   localparam int BEEP_MS = 20;
   localparam int TONE_HZ = 1000;
   localparam int SYNC_BIT_NS = 400;
   localparam int WDOG_CYC_DEF = WDOG_MS * (CLK_HZ / 1000);
   localparam int RELAY_CYC_DEF = RELAY_MS * (CLK_HZ / 1000);
   localparam int BEEP_CYC_DEF = BEEP_MS * (CLK_HZ / 1000);
   localparam int TONE_HALF_DEF = CLK_HZ / (2 * TONE_HZ);
   localparam logic [3:0] SYNC_BIT_CYC = 4'(SYNC_BIT_NS * CLK_MHZ / 1000);
   localparam logic [4:0] SPOT_BITS = 5'h10;

   typedef enum logic [1:0] {KEY_OFF, KEY_PREP, KEY_TREAT, KEY_BAD} dpo_key_type;
   typedef enum logic [1:0] {SY_IDLE, SY_START, SY_DATA, SY_STOP} dpo_sync_type;

endpackage

// file: hdl/dpo_interlock.sv
// dose pulse counters, overflow interlock, relays, keyswitch and sync snooper
// Operation
// [R1] count each rising pulse of at least 240 ns, up to 2 MHz
// [R2] with coax input fitted, flag a disconnected pulse cable as fault
// [R3] qualified counter advances only on pulses while counting not inhibited
// [R4] either gate input high means beam not inhibited
// [R5] unfiltered counter totals every pulse since last counter reset
// [R6] overdose judged on the qualified counter only
// [R7] audio beeps derive from unfiltered pulses
// [R8] beep volume adjustable but never zero
// [R9] host loads the overflow target before treatment
// [R10] open overflow relay when qualified count exceeds target
// [R11] overflow relay closed normally, open only on overflow or watchdog
// [R12] both counters readable by the host
// [R13] decode off, prepare, treat key position and report it
// [R14] each key contact closed exactly while key is in its position
// [R15] pause relay closed only in treat with pause press detected
// [R16] capture pause button press for software
// [R17] secondary stop relay opens when watchdog fires
// [R18] flag relay whose sensed state disagrees with command
// [R19] button rings green when allowed, red when suppressed
// [R20] decode spot number from the sync fibre input
// [R21] optionally retransmit sync fibre signal on the output fibre
// [R22] one beep per configured number of unfiltered pulses
// [R23] overflow opening holds until an explicit counter reset
// [R24] pulse input synchronised and edge detected, one count per pulse
module dpo_interlock #(
   parameter int WDOG_CYC = dpo_pkg::WDOG_CYC_DEF,
   parameter int RELAY_CYC = dpo_pkg::RELAY_CYC_DEF,
   parameter int BEEP_CYC = dpo_pkg::BEEP_CYC_DEF,
   parameter int TONE_HALF = dpo_pkg::TONE_HALF_DEF
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic pulseIn,
   input wire logic gateA,
   input wire logic gateB,
   input wire logic coaxFitted,
   input wire logic cableSense,
   input wire logic keyOff,
   input wire logic keyPrep,
   input wire logic keyTreat,
   input wire logic pauseButton,
   input wire logic overflowRelaySense,
   input wire logic stopRelaySense,
   input wire logic pauseRelaySense,
   input wire logic syncIn,
   output logic syncOut,
   output logic overflowRelay,
   output logic stopRelay,
   output logic pauseRelay,
   output logic keyOffContact,
   output logic keyPrepContact,
   output logic keyTreatContact,
   output logic startGreen,
   output logic startRed,
   output logic pauseGreen,
   output logic pauseRed,
   output logic audioOut,
   output logic [3:0] audioVolume
);
   import dpo_pkg::*;

   typedef struct packed {
      logic waitReq;
      logic [31:0] rdata;
      logic [2:0] pulseSync;
      logic [31:0] unfilt;
      logic [31:0] filt;
      logic [31:0] target;
      logic ovf;
      logic retx;
      logic wdEn;
      logic startOk;
      logic pauseOk;
      logic [15:0] ppt;
      logic [3:0] vol;
      logic [15:0] beepCnt;
      logic [23:0] beepTimer;
      logic [23:0] toneTimer;
      logic tone;
      logic [23:0] wdTimer;
      logic wdFired;
      logic [23:0] relayTimer;
      logic relayFault;
      logic pausePressed;
      logic cableFault;
      dpo_key_type keyPos;
      dpo_sync_type syState;
      logic [3:0] bitTimer;
      logic [4:0] bitIdx;
      logic [15:0] shift;
      logic [15:0] spot;
      logic spotValid;
      logic syncOut;
      logic ovfRelay;
      logic stopRelay;
      logic pauseRelay;
      logic [2:0] keyContact;
   } dpo_state_type;

   dpo_state_type r_reg, r_next;
   logic rise, qualified, wrEn, cmdRst, beepStart, mismatch;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [31:0] cw;
      r_next = r_reg;
      cw = 32'h0;
      // one wait cycle, then a single cycle with waitrequest low
      r_next.waitReq = ~((avs_read | avs_write) & r_reg.waitReq);
      wrEn = avs_write & ~r_reg.waitReq;
      cmdRst = wrEn && avs_address == ADDR_CTRL && avs_byteenable[0] &&
         avs_writedata[CTRL_CNTRST];

      // pulse path
      r_next.pulseSync = {r_reg.pulseSync[1:0], pulseIn}; // [R24]
      rise = r_reg.pulseSync[1] & ~r_reg.pulseSync[2]; // [R1] [R24]
      qualified = rise & (gateA | gateB); // [R4]
      if (cmdRst) begin
         r_next.unfilt = 32'h0;
         r_next.filt = 32'h0;
         r_next.ovf = 1'b0;
      end else begin
         r_next.unfilt = r_reg.unfilt + {31'h0, rise}; // [R5]
         r_next.filt = r_reg.filt + {31'h0, qualified}; // [R3]
         if (r_reg.filt > r_reg.target) begin
            r_next.ovf = 1'b1; // [R6] [R10] [R23]
         end
      end

      // beep per configured number of unfiltered pulses
      beepStart = 1'b0;
      if (cmdRst) begin
         r_next.beepCnt = 16'h0;
      end else if (rise) begin
         if (r_reg.beepCnt + 16'h1 >= r_reg.ppt) begin
            r_next.beepCnt = 16'h0;
            beepStart = 1'b1; // [R7] [R22]
         end else begin
            r_next.beepCnt = r_reg.beepCnt + 16'h1;
         end
      end
      if (beepStart) begin
         r_next.beepTimer = 24'(BEEP_CYC);
      end else if (r_reg.beepTimer != 24'h0) begin
         r_next.beepTimer = r_reg.beepTimer - 24'h1;
      end
      if (r_reg.beepTimer == 24'h0) begin
         r_next.toneTimer = 24'h0;
         r_next.tone = 1'b0;
      end else if (r_reg.toneTimer >= 24'(TONE_HALF - 1)) begin
         r_next.toneTimer = 24'h0;
         r_next.tone = ~r_reg.tone;
      end else begin
         r_next.toneTimer = r_reg.toneTimer + 24'h1;
      end

      // watchdog, kicked by any write to the kick register
      if (!r_reg.wdEn || (wrEn && avs_address == ADDR_KICK)) begin
         r_next.wdTimer = 24'h0;
      end else if (r_reg.wdTimer >= 24'(WDOG_CYC - 1)) begin
         r_next.wdFired = 1'b1;
      end else begin
         r_next.wdTimer = r_reg.wdTimer + 24'h1;
      end

      // key decode and contacts
      case ({keyTreat, keyPrep, keyOff})
         3'b001: r_next.keyPos = KEY_OFF; // [R13]
         3'b010: r_next.keyPos = KEY_PREP;
         3'b100: r_next.keyPos = KEY_TREAT;
         default: r_next.keyPos = KEY_BAD;
      endcase
      r_next.keyContact = {r_next.keyPos == KEY_TREAT, r_next.keyPos == KEY_PREP,
         r_next.keyPos == KEY_OFF}; // [R14]

      // cable disconnect only meaningful with coax input
      r_next.cableFault = coaxFitted & ~cableSense; // [R2]

      // register writes
      if (wrEn) begin
         case (avs_address)
            ADDR_CTRL: begin
               cw = mergeBytes({27'h0, r_reg.pauseOk, r_reg.startOk, r_reg.wdEn,
                  r_reg.retx, 1'b0}, avs_writedata, avs_byteenable);
               r_next.retx = cw[CTRL_RETX];
               r_next.wdEn = cw[CTRL_WDEN];
               r_next.startOk = cw[CTRL_STARTOK];
               r_next.pauseOk = cw[CTRL_PAUSEOK];
            end
            ADDR_TARGET: begin
               r_next.target = mergeBytes(r_reg.target, avs_writedata, avs_byteenable);
            end
            ADDR_STATUS: begin
               if (avs_byteenable[0] && avs_writedata[ST_PAUSE]) begin
                  r_next.pausePressed = 1'b0;
               end
            end
            ADDR_BEEP: begin
               cw = mergeBytes({12'h0, r_reg.vol, r_reg.ppt}, avs_writedata, avs_byteenable);
               r_next.ppt = cw[BEEP_PPT +: 16];
               r_next.vol = (cw[BEEP_VOL +: 4] == 4'h0) ? VOL_MIN : cw[BEEP_VOL +: 4]; // [R8]
            end
            default: begin
            end
         endcase
      end
      if (pauseButton) begin
         r_next.pausePressed = 1'b1; // [R16]
      end

      // relay commands
      r_next.ovfRelay = ~(r_next.ovf | r_next.wdFired); // [R10] [R11]
      r_next.stopRelay = ~r_next.wdFired; // [R17]
      r_next.pauseRelay = (r_next.keyPos == KEY_TREAT) & r_next.pausePressed; // [R15]

      // sensed relay state must follow the command within the settle time
      mismatch = (r_reg.ovfRelay != overflowRelaySense) |
         (r_reg.stopRelay != stopRelaySense) | (r_reg.pauseRelay != pauseRelaySense);
      if (!mismatch) begin
         r_next.relayTimer = 24'h0;
      end else if (r_reg.relayTimer >= 24'(RELAY_CYC - 1)) begin
         r_next.relayFault = 1'b1; // [R18]
      end else begin
         r_next.relayTimer = r_reg.relayTimer + 24'h1;
      end
      if (cmdRst && !(mismatch && r_reg.relayTimer >= 24'(RELAY_CYC - 1))) begin
         r_next.relayFault = 1'b0;
      end

      // sync snooper, start bit low, 16 bits lsb first, stop bit high
      r_next.syncOut = r_reg.retx ? syncIn : 1'b1; // [R21]
      case (r_reg.syState)
         SY_IDLE: begin
            r_next.bitTimer = 4'h0;
            if (!syncIn) begin
               r_next.syState = SY_START;
            end
         end
         SY_START: begin
            r_next.bitTimer = r_reg.bitTimer + 4'h1;
            if (r_reg.bitTimer == (SYNC_BIT_CYC >> 1)) begin
               r_next.bitTimer = 4'h0;
               r_next.bitIdx = 5'h0;
               r_next.syState = syncIn ? SY_IDLE : SY_DATA;
            end
         end
         SY_DATA: begin
            r_next.bitTimer = r_reg.bitTimer + 4'h1;
            if (r_reg.bitTimer == SYNC_BIT_CYC - 4'h1) begin
               r_next.bitTimer = 4'h0;
               r_next.shift = {syncIn, r_reg.shift[15:1]}; // [R20]
               r_next.bitIdx = r_reg.bitIdx + 5'h1;
               if (r_reg.bitIdx == SPOT_BITS - 5'h1) begin
                  r_next.syState = SY_STOP;
               end
            end
         end
         SY_STOP: begin
            r_next.bitTimer = r_reg.bitTimer + 4'h1;
            if (r_reg.bitTimer == SYNC_BIT_CYC - 4'h1) begin
               if (syncIn) begin
                  r_next.spot = r_reg.shift; // [R20]
                  r_next.spotValid = 1'b1;
               end
               r_next.syState = SY_IDLE;
            end
         end
         default: begin
            r_next.syState = SY_IDLE;
         end
      endcase

      // read data, captured in the wait cycle
      if (avs_read && r_reg.waitReq) begin
         case (avs_address)
            ADDR_CTRL: r_next.rdata = {27'h0, r_reg.pauseOk, r_reg.startOk, r_reg.wdEn,
               r_reg.retx, 1'b0};
            ADDR_TARGET: r_next.rdata = r_reg.target;
            ADDR_FILT: r_next.rdata = r_reg.filt; // [R12]
            ADDR_UNFILT: r_next.rdata = r_reg.unfilt; // [R12]
            ADDR_STATUS: r_next.rdata = {24'h0, r_reg.spotValid, r_reg.wdFired,
               r_reg.relayFault, r_reg.cableFault, r_reg.ovf, r_reg.pausePressed,
               r_reg.keyPos}; // [R13]
            ADDR_BEEP: r_next.rdata = {12'h0, r_reg.vol, r_reg.ppt};
            ADDR_SPOT: r_next.rdata = {16'h0, r_reg.spot};
            default: r_next.rdata = 32'h0;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.waitReq <= 1'b1;
         r_reg.ppt <= PPT_RST;
         r_reg.vol <= VOL_RST;
         r_reg.keyPos <= KEY_BAD;
         r_reg.syState <= SY_IDLE;
         r_reg.syncOut <= 1'b1;
         r_reg.ovfRelay <= 1'b1;
         r_reg.stopRelay <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign avs_readdata = r_reg.rdata;
   assign avs_waitrequest = r_reg.waitReq;
   assign syncOut = r_reg.syncOut;
   assign overflowRelay = r_reg.ovfRelay;
   assign stopRelay = r_reg.stopRelay;
   assign pauseRelay = r_reg.pauseRelay;
   assign keyOffContact = r_reg.keyContact[0];
   assign keyPrepContact = r_reg.keyContact[1];
   assign keyTreatContact = r_reg.keyContact[2];
   assign startGreen = r_reg.startOk; // [R19]
   assign startRed = ~r_reg.startOk; // [R19]
   assign pauseGreen = r_reg.pauseOk; // [R19]
   assign pauseRed = ~r_reg.pauseOk; // [R19]
   assign audioOut = r_reg.tone; // [R7]
   assign audioVolume = r_reg.vol;

   // ****************************************
   // checks
   // ****************************************
   unfilt_count_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
      rise && !cmdRst |=> r_reg.unfilt == $past(r_reg.unfilt) + 32'h1)
      else $error("unfiltered count missed a pulse");
   filt_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
      rise && !gateA && !gateB && !cmdRst |=> $stable(r_reg.filt))
      else $error("filtered count advanced while inhibited");
   overflow_open_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
      r_reg.filt > r_reg.target && !cmdRst |=> !overflowRelay)
      else $error("overflow relay not opened");
   overflow_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R23]
      !overflowRelay && !cmdRst |=> !overflowRelay)
      else $error("overflow relay reclosed without reset");
   watchdog_relays_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
      r_reg.wdFired |-> !stopRelay && !overflowRelay)
      else $error("relay closed after watchdog");
   key_contact_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
      keyTreat && !keyPrep && !keyOff |=> keyTreatContact && !keyPrepContact && !keyOffContact)
      else $error("key contacts wrong for treat");
   pause_relay_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
      pauseRelay |-> r_reg.keyPos == KEY_TREAT && r_reg.pausePressed)
      else $error("pause relay closed outside treat press");
   pause_latch_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
      pauseButton |=> r_reg.pausePressed)
      else $error("pause press not captured");
   volume_floor_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
      audioVolume != 4'h0)
      else $error("beep muted");
   cable_fault_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
      coaxFitted && !cableSense |=> r_reg.cableFault)
      else $error("cable disconnect not flagged");
   bus_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");

endmodule

// file: verification/dpo_partner.sv
// behavioural electrometer pulse source and sync fibre sender
module dpo_partner (
   input wire logic mclk,
   output logic pulseIn,
   output logic syncIn
);
   timeunit 1ns;
   timeprecision 1ps;
   import dpo_pkg::*;

   initial begin
      pulseIn = 1'b0;
      syncIn = 1'b1;
   end

   // ****************************************
   // pulse train, widths in clock cycles
   // ****************************************
   task automatic pulses(input int n, input int hi, input int lo);
      for (int i = 0; i < n; i++) begin
         pulseIn <= 1'b1;
         repeat (hi) @(posedge mclk);
         pulseIn <= 1'b0;
         repeat (lo) @(posedge mclk);
      end
   endtask

   // ****************************************
   // sync frame: start low, 16 bits lsb first, stop high
   // ****************************************
   task automatic sendSpot(input logic [15:0] v);
      logic [17:0] frame;
      frame = {1'b1, v, 1'b0};
      for (int i = 0; i < 18; i++) begin
         syncIn <= frame[i];
         repeat (SYNC_BIT_CYC) @(posedge mclk);
      end
   endtask
endmodule

// file: verification/tb_dpo_interlock.sv
// self-checking bench for the dose pulse overflow interlock
module tb_dpo_interlock;
   timeunit 1ns;
   timeprecision 1ps;
   import dpo_pkg::*;

   logic mclk, rst_n, avsRead, avsWrite, avsWaitrequest, weld, hit;
   logic [5:0] avsAddress;
   logic [31:0] avsWriteData, avsReaddata;
   logic [3:0] avsByteEnable, audioVolume, laneMask;
   logic pulseIn, gateA, gateB, coaxFitted, cableSense, keyOff, keyPrep, keyTreat;
   logic pauseButton, ovfSense, stopSense, pauseSense, syncIn, syncOut;
   logic overflowRelay, stopRelay, pauseRelay, offC, prepC, treatC;
   logic startGreen, startRed, pauseGreen, pauseRed, audioOut;
   int nMismatch = 0;
   int numChecks = 0;

   dpo_interlock #(.WDOG_CYC(50), .RELAY_CYC(20), .BEEP_CYC(30), .TONE_HALF(3)) uut (
      .mclk(mclk), .rst_n(rst_n), .avs_address(avsAddress), .avs_read(avsRead),
      .avs_write(avsWrite), .avs_writedata(avsWriteData), .avs_byteenable(avsByteEnable),
      .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .pulseIn(pulseIn),
      .gateA(gateA), .gateB(gateB), .coaxFitted(coaxFitted), .cableSense(cableSense),
      .keyOff(keyOff), .keyPrep(keyPrep), .keyTreat(keyTreat), .pauseButton(pauseButton),
      .overflowRelaySense(ovfSense), .stopRelaySense(stopSense),
      .pauseRelaySense(pauseSense), .syncIn(syncIn), .syncOut(syncOut),
      .overflowRelay(overflowRelay), .stopRelay(stopRelay), .pauseRelay(pauseRelay),
      .keyOffContact(offC), .keyPrepContact(prepC), .keyTreatContact(treatC),
      .startGreen(startGreen), .startRed(startRed), .pauseGreen(pauseGreen),
      .pauseRed(pauseRed), .audioOut(audioOut), .audioVolume(audioVolume));

   dpo_partner src (.mclk(mclk), .pulseIn(pulseIn), .syncIn(syncIn));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // relay contacts follow their coils one cycle late; weld holds pause closed
   always @(posedge mclk) begin
      ovfSense <= overflowRelay;
      stopSense <= stopRelay;
      pauseSense <= pauseRelay | weld;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
      output logic [31:0] q);
      avsAddress <= a;
      avsWriteData <= d;
      avsByteEnable <= laneMask;
      if (w) avsWrite <= 1'b1;
      else avsRead <= 1'b1;
      do @(posedge mclk); while (avsWaitrequest !== 1'b0);
      q = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdChk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic watchAudio(input int n, output logic h);
      h = 1'b0;
      repeat (n) begin
         @(posedge mclk);
         h = h | (audioOut === 1'b1);
      end
   endtask

   task automatic stopTest;
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      nMismatch++;
      stopTest;
   end

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      {avsRead, avsWrite, avsAddress, avsWriteData, avsByteEnable} = '0;
      laneMask = 4'hF;
      {gateA, gateB, keyPrep, keyTreat, pauseButton, weld} = '0;
      {coaxFitted, cableSense, keyOff} = 3'h7;
      cyc(10);
      rst_n <= 1'b1;
      cyc(2);
      chk(32'({overflowRelay, stopRelay, pauseRelay}), 32'h6);
      chk(32'({startGreen, startRed, pauseGreen, pauseRed}), 32'h5);
      chk(32'({audioVolume, syncOut}), 32'h11);
      rdChk(ADDR_BEEP, 32'hFFFFFFFF, {12'h0, VOL_RST, PPT_RST});
      rdChk(ADDR_TARGET, 32'hFFFFFFFF, 32'h0);
      wr(6'h20, 32'h5A5A5A5A);
      rdChk(6'h20, 32'hFFFFFFFF, 32'h0);
      for (int k = 0; k < 4; k++) begin
         {keyTreat, keyPrep, keyOff} <= (k == 3) ? 3'h0 : 3'(1 << k);
         cyc(2);
         chk(32'({treatC, prepC, offC}), (k == 3) ? 32'h0 : 32'(1 << k));
         rdChk(ADDR_STATUS, 32'h3, 32'(k));
      end
      wr(ADDR_TARGET, 32'h5);
      wr(ADDR_FILT, 32'h7);
      src.pulses(3, 25, 25);
      cyc(4);
      rdChk(ADDR_UNFILT, 32'hFFFFFFFF, 32'h3);
      rdChk(ADDR_FILT, 32'hFFFFFFFF, 32'h0);
      gateA <= 1'b1;
      src.pulses(2, 25, 25);
      gateA <= 1'b0;
      gateB <= 1'b1;
      src.pulses(2, 6, 6);
      cyc(4);
      gateB <= 1'b0;
      rdChk(ADDR_FILT, 32'hFFFFFFFF, 32'h4);
      rdChk(ADDR_UNFILT, 32'hFFFFFFFF, 32'h7);
      chk(32'(overflowRelay), 32'h1);
      gateA <= 1'b1;
      src.pulses(1, 25, 6);
      chk(32'(overflowRelay), 32'h1);
      src.pulses(1, 25, 6);
      chk(32'(overflowRelay), 32'h0);
      rdChk(ADDR_STATUS, 32'h8, 32'h8);
      gateA <= 1'b0;
      cyc(50);
      chk(32'(overflowRelay), 32'h0);
      wr(ADDR_CTRL, 32'h1);
      cyc(2);
      chk(32'(overflowRelay), 32'h1);
      rdChk(ADDR_FILT, 32'hFFFFFFFF, 32'h0);
      {keyTreat, keyPrep} <= 2'b10;
      cyc(3);
      chk(32'(pauseRelay), 32'h0);
      pauseButton <= 1'b1;
      cyc(3);
      pauseButton <= 1'b0;
      cyc(3);
      chk(32'(pauseRelay), 32'h1);
      rdChk(ADDR_STATUS, 32'h4, 32'h4);
      {keyTreat, keyPrep} <= 2'b01;
      cyc(3);
      chk(32'(pauseRelay), 32'h0);
      wr(ADDR_STATUS, 32'h4);
      rdChk(ADDR_STATUS, 32'h4, 32'h0);
      wr(ADDR_CTRL, 32'h18);
      cyc(2);
      chk(32'({startGreen, startRed, pauseGreen, pauseRed}), 32'hA);
      wr(ADDR_BEEP, 32'h00000002);
      rdChk(ADDR_BEEP, 32'hFFFFFFFF, 32'h00010002);
      chk(32'(audioVolume), 32'h1);
      wr(ADDR_CTRL, 32'h1);
      src.pulses(1, 25, 0);
      watchAudio(40, hit);
      chk(32'(hit), 32'h0);
      src.pulses(1, 25, 0);
      watchAudio(40, hit);
      chk(32'(hit), 32'h1);
      cableSense <= 1'b0;
      cyc(3);
      rdChk(ADDR_STATUS, 32'h10, 32'h10);
      cableSense <= 1'b1;
      cyc(3);
      rdChk(ADDR_STATUS, 32'h10, 32'h0);
      {coaxFitted, cableSense} <= 2'b00;
      cyc(3);
      rdChk(ADDR_STATUS, 32'h10, 32'h0);
      {coaxFitted, cableSense} <= 2'b11;
      weld <= 1'b1;
      cyc(12);
      rdChk(ADDR_STATUS, 32'h20, 32'h0);
      cyc(20);
      rdChk(ADDR_STATUS, 32'h20, 32'h20);
      weld <= 1'b0;
      cyc(3);
      wr(ADDR_CTRL, 32'h1);
      rdChk(ADDR_STATUS, 32'h20, 32'h0);
      wr(ADDR_CTRL, 32'h2);
      fork
         src.sendSpot(16'hA5C3);
         begin
            cyc(4);
            chk(32'(syncOut), 32'h0);
         end
      join
      cyc(3);
      rdChk(ADDR_SPOT, 32'hFFFF, 32'hA5C3);
      rdChk(ADDR_STATUS, 32'h80, 32'h80);
      wr(ADDR_CTRL, 32'h0);
      fork
         src.sendSpot(16'h3C5A);
         begin
            cyc(4);
            chk(32'(syncOut), 32'h1);
         end
      join
      cyc(3);
      rdChk(ADDR_SPOT, 32'hFFFF, 32'h3C5A);
      wr(ADDR_CTRL, 32'h4);
      cyc(25);
      wr(ADDR_KICK, 32'h0);
      cyc(30);
      chk(32'({stopRelay, overflowRelay}), 32'h3);
      cyc(40);
      chk(32'({stopRelay, overflowRelay}), 32'h0);
      rdChk(ADDR_STATUS, 32'h40, 32'h40);
      laneMask = 4'h1;
      wr(ADDR_TARGET, 32'hFFFFFF07);
      laneMask = 4'hF;
      rdChk(ADDR_TARGET, 32'hFFFFFFFF, 32'h7);
      stopTest;
   end
endmodule
